//--- logic/eid_external_interrupt_detect.sv
// Purpose: External interrupt pin detection, request flags and call sequencing.
// Assumes: CPU status inputs are on clk_i; pins are asynchronous.
// Notes: Register reads answer one cycle after the read strobe.
`timescale 1ns/100ps
`default_nettype none

module eid_external_interrupt_detect
	import eid_pkg::*;
#(
	parameter int MCYCLE_CLKS = EID_MCYCLE_CLKS,
	parameter int SAMPLE_PHASE = EID_SAMPLE_PHASE
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic ext0_request_pin_n_i,
	input wire logic ext1_request_pin_n_i,
	input wire logic ext2_request_pin_i,
	input wire logic ext3_request_pin_i,
	input wire logic ext4_request_pin_i,
	input wire logic ext5_request_pin_i,
	input wire logic ext6_request_pin_i,
	input wire logic timer2_ext_trigger_pin_i,
	input wire logic insn_last_cycle_i,
	input wire logic insn_blocks_i,
	input wire logic [7:0] in_service_block_i,
	input wire logic [1:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	output logic [7:0] ext_request_flag_o,
	output logic call_o,
	output logic [2:0] call_src_o,
	output logic service_start_o,
	output logic mcycle_end_o,
	output logic irq_o
);

	localparam logic [3:0] LAST_PHASE = 4'(MCYCLE_CLKS - 1);
	localparam logic [3:0] SAMPLE_AT = 4'(SAMPLE_PHASE);
	localparam logic [1:0] CALL_LAST = 2'(EID_CALL_MCYCLES - 1);

	logic [7:0] pins_raw;
	logic [7:0] sync1_reg;
	logic [7:0] sync2_reg;
	logic [3:0] phase_reg, phase_next;
	logic sample_stb, mcycle_end;
	logic [7:0] samp_reg, samp_next;
	logic [7:0] fall, rise, set_vec, level_mode;
	logic [7:0] timer_control_reg, timer_control_next;
	logic [7:0] flag_reg, flag_next;
	logic [7:0] status_reg, status_next;
	logic [7:0] mask_reg, mask_next;
	logic [7:0] poll_reg, poll_next;
	logic [7:0] call_clear, sw_clear, cand;
	logic [7:0] rdata_reg, rdata_next;
	eid_call_state_type state_reg, state_next;
	logic [1:0] mcnt_reg, mcnt_next;
	logic [2:0] src_reg, src_next;
	logic start_call;
	logic svc_reg, svc_next;
	logic irq_reg, irq_next;
	logic mend_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	// Pins 0 and 1 kept at pin polarity: low means request
	assign pins_raw = {timer2_ext_trigger_pin_i, ext6_request_pin_i, ext5_request_pin_i, ext4_request_pin_i,
		ext3_request_pin_i, ext2_request_pin_i, ext1_request_pin_n_i, ext0_request_pin_n_i};

	// Two stages per pin; only stage two feeds the detectors
	genvar gi;
	generate
		for (gi = 0; gi < EID_NUM_SRC; gi++) begin : g_sync
			always_ff @(posedge clk_i) begin
				if (srst_i) begin
					sync1_reg[gi] <= 1'b1;
					sync2_reg[gi] <= 1'b1;
				end else begin
					sync1_reg[gi] <= pins_raw[gi];
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Machine cycle phase counter

	// One sample strobe and one end-of-cycle strobe per machine cycle
	always_comb begin
		phase_next = (phase_reg == LAST_PHASE) ? 4'h0 : phase_reg + 4'h1;
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			phase_reg <= 4'h0;
		end else begin
			phase_reg <= phase_next;
		end
	end

	assign sample_stb = (phase_reg == SAMPLE_AT);
	assign mcycle_end = (phase_reg == LAST_PHASE);

	////////////////////////////////////////////////////////////////////////////////
	// Sampling and edge detection

	// Previous sample kept one machine cycle; reset value is all-high, so pins idling high give no false edge
	always_comb begin
		samp_next = sample_stb ? sync2_reg : samp_reg;
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			samp_reg <= 8'hFF;
		end else begin
			samp_reg <= samp_next;
		end
	end

	// Compare two consecutive synchronised samples
	assign fall = samp_reg & ~sync2_reg;
	assign rise = ~samp_reg & sync2_reg;

	// Level mode applies only to inputs 0 and 1 with trigger type clear
	assign level_mode = {6'h00, ~timer_control_reg[EID_CFG_EXT1_TYPE], ~timer_control_reg[EID_CFG_EXT0_TYPE]};

	// Per-source set condition, valid in the sample strobe cycle only
	always_comb begin
		set_vec = 8'h00;
		if (sample_stb) begin
			set_vec[EID_SRC_EXT0] = level_mode[EID_SRC_EXT0] ? ~sync2_reg[EID_SRC_EXT0] : fall[EID_SRC_EXT0];
			set_vec[EID_SRC_EXT1] = level_mode[EID_SRC_EXT1] ? ~sync2_reg[EID_SRC_EXT1] : fall[EID_SRC_EXT1];
			set_vec[EID_SRC_EXT2] = timer_control_reg[EID_CFG_EXT2_POL] ? rise[EID_SRC_EXT2] : fall[EID_SRC_EXT2];
			set_vec[EID_SRC_EXT3] = timer_control_reg[EID_CFG_EXT3_POL] ? rise[EID_SRC_EXT3] : fall[EID_SRC_EXT3];
			set_vec[EID_SRC_EXT6:EID_SRC_EXT4] = rise[EID_SRC_EXT6:EID_SRC_EXT4];
			set_vec[EID_SRC_RELOAD] = timer_control_reg[EID_CFG_RELOAD_EN] & fall[EID_SRC_RELOAD];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Request flags, event status and mask

	// Software write-one clears on the flag and status registers
	assign sw_clear = (reg_wr_i && reg_addr_i == EID_IDX_FLAGS) ? reg_wdata_i : 8'h00;

	// Level-mode flags follow the sampled pin; others are sticky and set wins over clear
	always_comb begin
		flag_next = flag_reg;
		for (int i = 0; i < EID_NUM_SRC; i++) begin
			if (level_mode[i]) begin
				flag_next[i] = sample_stb ? set_vec[i] : flag_reg[i];
			end else if (set_vec[i]) begin
				flag_next[i] = 1'b1;
			end else if (call_clear[i] || sw_clear[i]) begin
				flag_next[i] = 1'b0;
			end
		end
		status_next = (status_reg & ~((reg_wr_i && reg_addr_i == EID_IDX_STATUS) ? reg_wdata_i : 8'h00))
			| (set_vec & ~flag_reg);
		mask_next = (reg_wr_i && reg_addr_i == EID_IDX_MASK) ? reg_wdata_i : mask_reg;
		timer_control_next = (reg_wr_i && reg_addr_i == EID_IDX_CONFIG) ? (reg_wdata_i & EID_CFG_WMASK)
			: timer_control_reg;
		irq_next = |(status_next & mask_next);
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			flag_reg <= 8'h00;
			status_reg <= 8'h00;
			mask_reg <= EID_MASK_RESET;
			timer_control_reg <= EID_CFG_RESET;
			irq_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
			status_reg <= status_next;
			mask_reg <= mask_next;
			timer_control_reg <= timer_control_next;
			irq_reg <= irq_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Polling and call sequencer

	// Poll copy taken at cycle end, so a flag set at the sample strobe is seen next cycle
	always_comb begin
		poll_next = mcycle_end ? flag_reg : poll_reg;
	end

	// Candidates are only what is pending now; nothing blocked is remembered
	assign cand = poll_reg & ~in_service_block_i;
	// Call only in the final cycle of an instruction that does not block vectoring
	assign start_call = (state_reg == EID_ST_IDLE) && mcycle_end && insn_last_cycle_i && !insn_blocks_i
		&& (|cand);

	// The called source's flag is cleared when the call starts if in edge mode; level-mode flags stay
	always_comb begin
		call_clear = 8'h00;
		if (start_call) begin
			call_clear[src_next] = ~level_mode[src_next];
		end
	end

	// Call lasts two machine cycles, then the first service instruction starts
	always_comb begin
		state_next = state_reg;
		mcnt_next = mcnt_reg;
		src_next = src_reg;
		svc_next = 1'b0;
		case (state_reg)
			EID_ST_IDLE: begin
				src_next = start_call ? eid_pick(cand) : src_reg;
				if (start_call) begin
					state_next = EID_ST_CALL;
					mcnt_next = 2'h0;
				end
			end
			EID_ST_CALL: begin
				if (mcycle_end) begin
					mcnt_next = mcnt_reg + 2'h1;
					if (mcnt_reg == CALL_LAST) begin
						state_next = EID_ST_IDLE;
						svc_next = 1'b1;
					end
				end
			end
			default: begin
				state_next = EID_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			poll_reg <= 8'h00;
			state_reg <= EID_ST_IDLE;
			mcnt_reg <= 2'h0;
			src_reg <= 3'h0;
			svc_reg <= 1'b0;
			mend_reg <= 1'b0;
		end else begin
			poll_reg <= poll_next;
			state_reg <= state_next;
			mcnt_reg <= mcnt_next;
			src_reg <= src_next;
			svc_reg <= svc_next;
			mend_reg <= mcycle_end;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register read port

	// Read data valid only in the cycle after the strobe; flags read live state
	always_comb begin
		rdata_next = 8'h00;
		if (reg_rd_i) begin
			case (reg_addr_i)
				EID_IDX_CONFIG: rdata_next = timer_control_reg;
				EID_IDX_FLAGS: rdata_next = flag_reg;
				EID_IDX_STATUS: rdata_next = status_reg;
				EID_IDX_MASK: rdata_next = mask_reg;
				default: rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// All outputs come straight from flops
	assign reg_rdata_o = rdata_reg;
	assign ext_request_flag_o = flag_reg;
	assign call_o = (state_reg == EID_ST_CALL);
	assign call_src_o = src_reg;
	assign service_start_o = svc_reg;
	assign mcycle_end_o = mend_reg;
	assign irq_o = irq_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	// Clocks spent in the call, checked against the fixed two machine cycles
	logic [5:0] call_len_reg;
	always_ff @(posedge clk_i) begin
		if (srst_i || start_call) begin
			call_len_reg <= 6'h00;
		end else if (state_reg == EID_ST_CALL) begin
			call_len_reg <= call_len_reg + 6'h01;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);

	AST_LEVEL_FOLLOWS: assert property (sample_stb && !timer_control_reg[EID_CFG_EXT0_TYPE]
		|=> flag_reg[EID_SRC_EXT0] == !$past(sync2_reg[EID_SRC_EXT0])) else $error("level flag wrong");
	AST_FALL_SETS: assert property (sample_stb && timer_control_reg[EID_CFG_EXT1_TYPE] && samp_reg[EID_SRC_EXT1]
		&& !sync2_reg[EID_SRC_EXT1] |=> flag_reg[EID_SRC_EXT1]) else $error("falling edge missed");
	AST_POL_RISE: assert property (sample_stb && timer_control_reg[EID_CFG_EXT2_POL] && !samp_reg[EID_SRC_EXT2]
		&& sync2_reg[EID_SRC_EXT2] |=> flag_reg[EID_SRC_EXT2]) else $error("rising edge missed");
	AST_NO_FALL_4: assert property (sample_stb && samp_reg[EID_SRC_EXT4] && !sync2_reg[EID_SRC_EXT4]
		&& !flag_reg[EID_SRC_EXT4] |=> !flag_reg[EID_SRC_EXT4]) else $error("fall set input 4");
	AST_RELOAD_GATED: assert property (!timer_control_reg[EID_CFG_RELOAD_EN] && !flag_reg[EID_SRC_RELOAD]
		|=> !flag_reg[EID_SRC_RELOAD]) else $error("reload flag set while disabled");
	AST_SET_AT_STROBE: assert property ($rose(flag_reg[EID_SRC_EXT3]) |-> $past(sample_stb))
		else $error("flag set off strobe");
	AST_CALL_CLEARS: assert property (start_call && !level_mode[eid_pick(cand)]
		|=> !flag_reg[src_reg]) else $error("call did not clear flag");
	AST_LEVEL_KEPT: assert property (start_call && level_mode[eid_pick(cand)] && flag_reg[eid_pick(cand)]
		|=> flag_reg[src_reg]) else $error("level flag cleared by call");
	AST_CALL_LEN: assert property ($rose(service_start_o) |-> call_len_reg == 6'(EID_CALL_MCYCLES * MCYCLE_CLKS)
		&& !call_o) else $error("call length wrong");
	AST_BLOCKING: assert property (start_call |-> insn_last_cycle_i && !insn_blocks_i
		&& poll_reg[eid_pick(cand)] && !in_service_block_i[eid_pick(cand)]) else $error("call while blocked");
	AST_SYNC_PATH: assert property (sample_stb |=> samp_reg == $past(sync1_reg, 2)) else $error("sync path wrong");

	COV_CALL: cover property (start_call);
	COV_SERVICE: cover property (service_start_o);
	COV_IRQ: cover property ($rose(irq_o));
	COV_BLOCKED: cover property (mcycle_end && |poll_reg && insn_blocks_i);

endmodule

`default_nettype wire

//--- logic/eid_pkg.sv
// Purpose: Constants, register map and types of the external interrupt detector.
// Assumes: clk_i is the oscillator; one machine cycle is twelve oscillator periods.
// Notes: Register indices are word indices on the plain register port.
// Notes on behaviour
// - Trigger-type bit of inputs 0 and 1: clear selects level, set selects falling edge.
// - Level mode on input 0 or 1 raises the request while a low is sampled.
// - Edge mode sets the flag when a high sample is followed by a low sample.
// - Polarity bit of inputs 2 and 3: 0 falling, 1 rising transition.
// - Inputs 4, 5 and 6 always trigger on a rising transition.
// - Reload flag sets on a falling trigger pin transition only while reload is enabled.
// - Pins are sampled once per machine cycle; sources hold levels twelve periods.
// - Request flags clear by hardware when the service call is made.
// - Flags set at state 5 phase 2 and are polled only in the next cycle.
// - An accepted request becomes a two-cycle call; at least three cycles to service.
// - A request waits while an equal or higher priority service is in progress.
// - Polling outside an instruction's last cycle defers the call, at most three cycles.
// - After a return or interrupt register write, one more instruction runs first.
// - Single-interrupt response latency is above three and below nine cycles.
// - Inputs 0 and 1 clear on the call only in transition mode, never in level mode.
// - A request blocked and then gone is not remembered; each poll sees only pending flags.

package eid_pkg;

	// Register port geometry
	localparam int EID_ADDR_W = 2;
	localparam int EID_DATA_W = 8;
	localparam int EID_NUM_SRC = 8;

	// Register indices
	localparam logic [1:0] EID_IDX_CONFIG = 2'h0;
	localparam logic [1:0] EID_IDX_FLAGS = 2'h1;
	localparam logic [1:0] EID_IDX_STATUS = 2'h2;
	localparam logic [1:0] EID_IDX_MASK = 2'h3;

	// Configuration bit positions
	localparam int EID_CFG_EXT0_TYPE = 0;
	localparam int EID_CFG_EXT1_TYPE = 1;
	localparam int EID_CFG_EXT2_POL = 2;
	localparam int EID_CFG_EXT3_POL = 3;
	localparam int EID_CFG_RELOAD_EN = 4;
	localparam logic [7:0] EID_CFG_WMASK = 8'h1F;
	localparam logic [7:0] EID_CFG_RESET = 8'h00;
	localparam logic [7:0] EID_MASK_RESET = 8'h00;

	// Source indices: flag, status and mask bits share this layout
	localparam int EID_SRC_EXT0 = 0;
	localparam int EID_SRC_EXT1 = 1;
	localparam int EID_SRC_EXT2 = 2;
	localparam int EID_SRC_EXT3 = 3;
	localparam int EID_SRC_EXT4 = 4;
	localparam int EID_SRC_EXT6 = 6;
	localparam int EID_SRC_RELOAD = 7;

	// Timing
	localparam int EID_CLK_PERIOD_NS = 50;
	localparam int EID_OSC_PERIOD_NS = 50;
	localparam int EID_MCYCLE_OSC = 12;
	localparam int EID_MCYCLE_NS = EID_MCYCLE_OSC * EID_OSC_PERIOD_NS;
	localparam int EID_MCYCLE_CLKS = (EID_MCYCLE_NS + EID_CLK_PERIOD_NS - 1) / EID_CLK_PERIOD_NS;
	localparam int EID_SAMPLE_PHASE = 9;
	localparam int EID_CALL_MCYCLES = 2;

	// Vectoring sequencer states
	typedef enum logic [0:0] {
		EID_ST_IDLE = 1'b0,
		EID_ST_CALL = 1'b1
	} eid_call_state_type;

	// Lowest set index wins: the fixed order within a priority level
	function automatic logic [2:0] eid_pick(input logic [7:0] req);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = EID_NUM_SRC - 1; i >= 0; i--) begin
			if (req[i]) begin
				idx = 3'(i);
			end
		end
		return idx;
	endfunction

endpackage

//--- test/eid_source_model.sv
// Purpose: Model of the external sources that drive the request pins.
// Assumes: Bit 0 and 1 are low-active inputs, 2 to 6 plain inputs, 7 the timer-2 trigger.
// Notes: Each level is held two machine cycles, so a slow source is the only kind modelled.
`timescale 1ns/100ps
`default_nettype none

module eid_source_model
	import eid_pkg::*;
#(
	parameter int HOLD_CLKS = 2 * EID_MCYCLE_CLKS
) (
	input wire logic clk_i,
	output logic [7:0] pins_o
);

	// Idle levels: low-active inputs and trigger high, the rest low
	initial begin
		pins_o = 8'h83;
	end

	// New level after an edge, held so the once-a-cycle sampler sees it
	task automatic drive(input logic [7:0] val);
		@(posedge clk_i);
		pins_o <= val;
		repeat (HOLD_CLKS) @(posedge clk_i);
	endtask

endmodule

`default_nettype wire

//--- test/tb_external_interrupt_detect.sv
// Purpose: Self-checking bench of the external interrupt detector.
// Assumes: One clock at 20 MHz; the CPU status inputs are driven by the bench.
// Notes: Random pin patterns run with calls disabled; calls are tested by hand.
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) begin \
	tests_run++; \
	if ((got) !== (exp)) begin \
		bad_count++; \
		$display("Error at %0t: got %0h expected %0h", $time, got, exp); \
	end \
end

module tb_external_interrupt_detect
	import eid_pkg::*;
;
	logic clk_i, srst_i, last_i, blocks_i, reg_wr_i, reg_rd_i;
	logic [7:0] in_svc_i, reg_wdata_i, reg_rdata_o, flag_o, pins, v, cfg, p0, p1, exp_f;
	logic [1:0] reg_addr_i;
	logic call_o, service_start_o, mcycle_end_o, irq_o;
	logic [2:0] call_src_o;
	logic [31:0] rng;
	int bad_count, tests_run, n;

	eid_source_model eid_source_model_inst (.clk_i(clk_i), .pins_o(pins));

	eid_external_interrupt_detect eid_external_interrupt_detect_inst (
		.clk_i(clk_i), .srst_i(srst_i),
		.ext0_request_pin_n_i(pins[0]), .ext1_request_pin_n_i(pins[1]),
		.ext2_request_pin_i(pins[2]), .ext3_request_pin_i(pins[3]),
		.ext4_request_pin_i(pins[4]), .ext5_request_pin_i(pins[5]),
		.ext6_request_pin_i(pins[6]), .timer2_ext_trigger_pin_i(pins[7]),
		.insn_last_cycle_i(last_i), .insn_blocks_i(blocks_i), .in_service_block_i(in_svc_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .ext_request_flag_o(flag_o), .call_o(call_o),
		.call_src_o(call_src_o), .service_start_o(service_start_o),
		.mcycle_end_o(mcycle_end_o), .irq_o(irq_o)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Expectation helpers

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction

	// Flags that a pin change o to n sets under configuration c
	function automatic logic [7:0] edges(input logic [7:0] c, input logic [7:0] o, input logic [7:0] n);
		logic [7:0] r, fall, rise;
		fall = o & ~n;
		rise = ~o & n;
		r = rise & 8'h70;
		r[0] = c[0] & fall[0];
		r[1] = c[1] & fall[1];
		r[2] = c[2] ? rise[2] : fall[2];
		r[3] = c[3] ? rise[3] : fall[3];
		r[7] = c[4] & fall[7];
		return r;
	endfunction

	// Level-mode inputs follow the inverted pin, edge bits accumulate
	function automatic logic [7:0] upd(input logic [7:0] f, input logic [7:0] c, input logic [7:0] o,
			input logic [7:0] n);
		f = f | edges(c, o, n);
		if (!c[0]) f[0] = ~n[0];
		if (!c[1]) f[1] = ~n[1];
		return f;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Register port and waits

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1;
		d = reg_rdata_o;
	endtask

	// Counts clocks with a call in progress; a bounded watch, never a wait
	task automatic watch(input int len, output int c);
		c = 0;
		repeat (len) begin
			@(posedge clk_i);
			#1;
			if (call_o) c++;
		end
	endtask

	// Bounded wait for the call or the service start; exhausting it ends the run
	task automatic wait_for(input bit svc, output int c);
		c = 0;
		do begin
			@(posedge clk_i);
			#1;
			c++;
		end while (!(svc ? service_start_o : call_o) && c < 200);
		if (c >= 200) begin
			bad_count++;
			$display("Error at %0t: wait ran out", $time);
			final_report();
		end
	endtask

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence

	initial begin
		srst_i = 1'b1;
		{last_i, blocks_i, reg_wr_i, reg_rd_i} = 4'h0;
		in_svc_i = 8'h00;
		reg_wdata_i = 8'h00;
		reg_addr_i = 2'h0;
		bad_count = 0;
		tests_run = 0;
		rng = 32'h00017382;
		repeat (20) @(posedge clk_i);
		srst_i <= 1'b0;
		rd(EID_IDX_CONFIG, v);
		`CHK(v, EID_CFG_RESET)
		rd(EID_IDX_MASK, v);
		`CHK(v, EID_MASK_RESET)
		wr(EID_IDX_CONFIG, 8'hFF);
		rd(EID_IDX_CONFIG, v);
		`CHK(v, EID_CFG_WMASK)
		// Random trigger setups and two pin steps each; calls held off by the CPU
		for (int i = 0; i < 40; i++) begin
			eid_source_model_inst.drive(8'h83);
			rng = xs(rng);
			cfg = rng[7:0] & EID_CFG_WMASK;
			if (i < 4) cfg = 8'h1F >> i;
			// CPU status drawn at random; a last cycle always comes with a blocking instruction
			in_svc_i <= rng[31:24];
			last_i <= rng[25];
			blocks_i <= rng[25] | rng[24];
			wr(EID_IDX_CONFIG, cfg);
			wr(EID_IDX_FLAGS, 8'hFF);
			p0 = rng[15:8];
			p1 = rng[23:16];
			exp_f = upd(8'h00, cfg, 8'h83, p0);
			eid_source_model_inst.drive(p0);
			rd(EID_IDX_FLAGS, v);
			`CHK(v, exp_f)
			exp_f = upd(exp_f, cfg, p0, p1);
			eid_source_model_inst.drive(p1);
			`CHK(flag_o, exp_f)
			`CHK(call_o, 1'b0)
		end
		// Unmasked event on input 2 raises the interrupt, then write-one clear of status
		eid_source_model_inst.drive(8'h83);
		wr(EID_IDX_CONFIG, 8'h04);
		wr(EID_IDX_FLAGS, 8'hFF);
		wr(EID_IDX_STATUS, 8'hFF);
		wr(EID_IDX_MASK, 8'h04);
		eid_source_model_inst.drive(8'h87);
		`CHK(irq_o, 1'b1)
		wr(EID_IDX_STATUS, 8'h04);
		repeat (2) @(posedge clk_i);
		`CHK(irq_o, 1'b0)
		wr(EID_IDX_MASK, 8'h00);
		eid_source_model_inst.drive(8'h83);
		// Status records a set made while the flag was clear; mask 0 keeps the interrupt low
		wr(EID_IDX_FLAGS, 8'hFF);
		eid_source_model_inst.drive(8'h87);
		rd(EID_IDX_STATUS, v);
		`CHK(v[2], 1'b1)
		`CHK(irq_o, 1'b0)
		// Edge request on input 0 held off by a blocking instruction and by service in progress
		eid_source_model_inst.drive(8'h83);
		wr(EID_IDX_CONFIG, 8'h01);
		wr(EID_IDX_FLAGS, 8'hFF);
		last_i <= 1'b1;
		blocks_i <= 1'b1;
		eid_source_model_inst.drive(8'h82);
		watch(36, n);
		`CHK(n, 0)
		blocks_i <= 1'b0;
		in_svc_i <= 8'h01;
		watch(36, n);
		`CHK(n, 0)
		`CHK(flag_o, 8'h01)
		in_svc_i <= 8'h00;
		wait_for(1'b0, n);
		`CHK(call_src_o, 3'h0)
		wait_for(1'b1, n);
		`CHK(n, EID_CALL_MCYCLES * EID_MCYCLE_CLKS)
		`CHK(call_o, 1'b0)
		`CHK(flag_o, 8'h00)
		// Level request on input 1 unblocked: latency, and the flag survives the call
		// Input 0 released first, else level mode on it would raise its own request
		eid_source_model_inst.drive(8'h83);
		wr(EID_IDX_CONFIG, 8'h00);
		fork
			eid_source_model_inst.drive(8'h81);
			wait_for(1'b1, n);
		join
		`CHK(n > 3 * EID_MCYCLE_CLKS && n < 9 * EID_MCYCLE_CLKS, 1'b1)
		`CHK(call_src_o, 3'h1)
		`CHK(flag_o[1], 1'b1)
		eid_source_model_inst.drive(8'h83);
		repeat (36) @(posedge clk_i);
		`CHK(flag_o, 8'h00)
		// Level request that disappears while blocked is never serviced
		blocks_i <= 1'b1;
		eid_source_model_inst.drive(8'h82);
		eid_source_model_inst.drive(8'h83);
		blocks_i <= 1'b0;
		watch(48, n);
		`CHK(n, 0)
		final_report();
	end

endmodule

`default_nettype wire
